//--- common/width_sync_map.vh
`ifndef WIDTH_SYNC_MAP_VH
`define WIDTH_SYNC_MAP_VH
// Width detection bytes on the low byte lane
`define WS_PAT_LEAD      8'hBB
`define WS_PAT_X8        8'h11
`define WS_PAT_X16       8'h22
`define WS_PAT_X32       8'h44
// Sync word, unswapped order
`define WS_SYNC_WORD     32'hAA995566
// Width codes
`define WS_WIDTH_NONE    2'h0
`define WS_WIDTH_X8      2'h1
`define WS_WIDTH_X16     2'h2
`define WS_WIDTH_X32     2'h3
// Mode codes
`define WS_MODE_PARALLEL 1'b0
`define WS_MODE_SERIAL   1'b1
// Start-up input quiet time
`define WS_CLK_MHZ       20
`define WS_QUIET_NS      200
`define WS_QUIET_CYC     ((`WS_QUIET_NS * `WS_CLK_MHZ + 999) / 1000)
`endif

//--- rtl/word_assembler.v
`timescale 1ns/1ps
// Packs narrow bus beats into 32-bit words, first beat in the top lane
module word_assembler (
   clk,
   rst_n,
   ce,
   clear,
   beat_valid,
   beat_data,
   beats_per_word,
   word_valid,
   word_data
);
   input  wire        clk;            // Clock
   input  wire        rst_n;          // Async reset
   input  wire        ce;             // Clock enable
   input  wire        clear;          // Restart packing
   input  wire        beat_valid;     // Beat present
   input  wire [31:0] beat_data;      // Beat, low bits used
   input  wire [2:0]  beats_per_word; // 1, 2 or 4
   output reg         word_valid;     // One-cycle word pulse
   output reg  [31:0] word_data;      // Packed word

   reg  [31:0] acc_r;                 // Packing accumulator
   reg  [2:0]  cnt_r;                 // Beats gathered
   reg  [31:0] acc_nxt;               // Next accumulator
   wire [2:0]  cnt_inc;               // Beats incl this one

   assign cnt_inc = cnt_r + 3'h1;

   // Shift the new beat in at the width of the bus
   always @* begin
      case (beats_per_word)
         3'h4:    acc_nxt = {acc_r[23:0], beat_data[7:0]};
         3'h2:    acc_nxt = {acc_r[15:0], beat_data[15:0]};
         default: acc_nxt = beat_data;
      endcase
   end

   // Count beats and emit a whole word
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r      <= 32'h0;
         cnt_r      <= 3'h0;
         word_valid <= 1'b0;
         word_data  <= 32'h0;
      end else if (ce) begin
         word_valid <= 1'b0;
         if (clear) begin
            cnt_r <= 3'h0;
         end else if (beat_valid) begin
            if (cnt_inc == beats_per_word) begin
               cnt_r      <= 3'h0;
               word_valid <= 1'b1;
               word_data  <= acc_nxt;
            end else begin
               cnt_r <= cnt_inc;
               acc_r <= acc_nxt;
            end
         end
      end
   end
endmodule // word_assembler

//--- rtl/config_bus_width_sync_detect.v
// Operation
// [R01] Parallel modes detect bus width themselves
// [R02] Serial modes skip width detection
// [R03] Detection looks only at low byte
// [R04] BB then 11 selects x8
// [R05] BB then 22 selects x16
// [R06] BB then 44 selects x32
// [R07] Bad code after BB restarts search
// [R08] Lock width, then seek sync word
// [R09] Width held until a reset source
// [R10] Sync word AA995566 aligns words
// [R11] Nothing passes before sync found
// [R12] Parallel sync search waits for width
// [R13] Memory accessed only in whole frames
// [R14] All frames share one length
// [R15] Low-voltage pin may pulse after start-up
// [R16] User ignores inputs 200 ns after
// [R17] After sync each word goes to packets
// [R18] One beat per edge, resets restart
// [R19] Serial sync slides bit by bit
`timescale 1ns/1ps
`include "width_sync_map.vh"
module config_bus_width_sync_detect (
   clk,
   rst_n,
   ce,
   serial_mode,
   program_pulse,
   scan_program_reset,
   internal_reprogram_reset,
   par_valid,
   par_data,
   ser_valid,
   ser_bit,
   startup_complete,
   bus_width,
   width_locked,
   synced,
   word_valid,
   word_data,
   user_input_hold
);
   input  wire        clk;                      // Configuration clock
   input  wire        rst_n;                    // Power-on reset
   input  wire        ce;                       // Clock enable
   input  wire        serial_mode;              // High for serial loading
   input  wire        program_pulse;            // Program pin pulse
   input  wire        scan_program_reset;       // Boundary-scan program
   input  wire        internal_reprogram_reset; // Internal reprogram
   input  wire        par_valid;                // Parallel beat present
   input  wire [31:0] par_data;                 // Parallel bus
   input  wire        ser_valid;                // Serial bit present
   input  wire        ser_bit;                  // Serial data bit
   input  wire        startup_complete;         // Start-up done level
   output reg  [1:0]  bus_width;                // Detected width code
   output reg         width_locked;             // Width fixed
   output reg         synced;                   // Sync word seen
   output reg         word_valid;               // Packet word pulse
   output reg  [31:0] word_data;                // Packet word
   output reg         user_input_hold;          // Inputs unsafe window

   // Width detector states
   localparam [1:0] ST_HUNT = 2'h0;             // Look for lead byte
   localparam [1:0] ST_CODE = 2'h1;             // Check width code
   localparam [1:0] ST_LOCK = 2'h2;             // Width fixed

   reg  [1:0]  wstate_r;                        // Width state
   reg  [1:0]  wstate_nxt;                      // Next width state
   reg  [1:0]  width_nxt;                       // Next width
   reg  [31:0] shift_r;                         // Sync search window
   reg  [31:0] shift_nxt;                       // Next window
   reg  [2:0]  bpw;                             // Beats per word
   reg         eos_d_r;                         // Start-up delayed
   reg  [2:0]  quiet_r;                         // Quiet counter
   reg         pulse_seen_r;                    // Glitch cycle passed
   wire        relock;                          // Any width-clearing reset
   wire [7:0]  low_byte;                        // Low byte lane
   wire        beat_par;                        // Beat into assembler
   wire        asm_valid;                       // Assembled word pulse
   wire [31:0] asm_data;                        // Assembled word
   wire [31:0] quiet_last;                      // Final quiet count
   reg  [4:0]  sbit_r;                          // Serial bit index

   assign relock   = program_pulse | scan_program_reset | internal_reprogram_reset;
   assign low_byte = par_data[7:0];             // R03
   // Last value of the quiet counter before the hold drops
   assign quiet_last = `WS_QUIET_CYC - 1;

   // Width detection next state
   // The detector only ever looks at the low byte lane; the other lanes
   // carry padding that differs between bus widths
   always @* begin
      wstate_nxt = wstate_r;
      width_nxt  = bus_width;
      case (wstate_r)
         ST_HUNT: begin
            // Waiting for the lead byte
            if (serial_mode == `WS_MODE_SERIAL) begin
               wstate_nxt = ST_HUNT;            // R02
            end else if (par_valid && low_byte == `WS_PAT_LEAD) begin
               wstate_nxt = ST_CODE;            // R01
            end
         end
         ST_CODE: begin
            // Lead byte seen; the next beat picks the width
            if (serial_mode == `WS_MODE_SERIAL) begin
               wstate_nxt = ST_HUNT;            // R02
            end else if (par_valid) begin
               if (low_byte == `WS_PAT_X8) begin
                  // Eight-bit bus
                  wstate_nxt = ST_LOCK;         // R04
                  width_nxt  = `WS_WIDTH_X8;
               end else if (low_byte == `WS_PAT_X16) begin
                  // Sixteen-bit bus
                  wstate_nxt = ST_LOCK;         // R05
                  width_nxt  = `WS_WIDTH_X16;
               end else if (low_byte == `WS_PAT_X32) begin
                  // Thirty-two-bit bus
                  wstate_nxt = ST_LOCK;         // R06
                  width_nxt  = `WS_WIDTH_X32;
               end else if (low_byte == `WS_PAT_LEAD) begin
                  // A fresh lead byte: wait for its code
                  wstate_nxt = ST_CODE;         // R07
               end else begin
                  // Not a width code: back to the hunt
                  wstate_nxt = ST_HUNT;         // R07
               end
            end
         end
         ST_LOCK: begin
            // Locked until a reprogram source or power cycle
            wstate_nxt = ST_LOCK;               // R09
         end
         default: begin
            // Unused code recovers to the hunt
            wstate_nxt = ST_HUNT;
         end
      endcase
   end

   // Width detector registers, cleared by any reprogram source
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wstate_r     <= ST_HUNT;
         bus_width    <= `WS_WIDTH_NONE;
         width_locked <= 1'b0;
      end else if (ce) begin
         if (relock) begin
            // Reprogram source drops the lock at once
            wstate_r     <= ST_HUNT;            // R18
            bus_width    <= `WS_WIDTH_NONE;
            width_locked <= 1'b0;
         end else begin
            // Follow the detector
            wstate_r     <= wstate_nxt;
            bus_width    <= width_nxt;          // R08
            width_locked <= (wstate_nxt == ST_LOCK);
         end
      end
   end

   // Beats per word at the locked width
   // Anything but a narrow bus hands over whole words
   always @* begin
      case (bus_width)
         `WS_WIDTH_X8:  bpw = 3'h4;
         `WS_WIDTH_X16: bpw = 3'h2;
         default:       bpw = 3'h1;
      endcase
   end

   // Only locked parallel beats enter the word path
   // Beats seen while hunting never reach the packer
   assign beat_par = par_valid & width_locked & (serial_mode == `WS_MODE_PARALLEL); // R12

   // Beat packer, one beat per clock edge
   // Held clear until sync so that the first packed word starts right
   // after the sync word and not at the width lock
   word_assembler u_asm (
      .clk            (clk),
      .rst_n          (rst_n),
      .ce             (ce),
      .clear          (relock | ~synced),
      .beat_valid     (beat_par),
      .beat_data      (par_data),
      .beats_per_word (bpw),
      .word_valid     (asm_valid),
      .word_data      (asm_data)
   ); // R18

   // Sync search window next value
   // Serial bits slide one at a time; parallel beats slide a bus width,
   // so the sync word must arrive aligned to the bus
   always @* begin
      shift_nxt = shift_r;
      if (serial_mode == `WS_MODE_SERIAL) begin
         if (ser_valid) begin
            shift_nxt = {shift_r[30:0], ser_bit}; // R19
         end
      end else if (!synced && par_valid && width_locked) begin
         case (bus_width)
            `WS_WIDTH_X8:  shift_nxt = {shift_r[23:0], par_data[7:0]};
            `WS_WIDTH_X16: shift_nxt = {shift_r[15:0], par_data[15:0]};
            default:       shift_nxt = par_data;
         endcase
      end
   end

   // Sync detection and word output
   // Before sync the window slides and every word is dropped; after it,
   // words leave from the packer (parallel) or the bit counter (serial)
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Power cycle clears the search
         shift_r    <= 32'h0;
         synced     <= 1'b0;
         word_valid <= 1'b0;
         word_data  <= 32'h0;
      end else if (ce) begin
         // Word pulse lasts one enabled cycle
         word_valid <= 1'b0;
         if (relock) begin
            // Reprogram source: start the search again
            shift_r <= 32'h0;                   // R18
            synced  <= 1'b0;
         end else if (!synced) begin
            // Still hunting: slide the window, keep nothing else
            shift_r <= shift_nxt;
            if (shift_nxt == `WS_SYNC_WORD &&
                (serial_mode == `WS_MODE_SERIAL || width_locked)) begin
               // Word boundary found; the window restarts empty
               synced  <= 1'b1;                 // R10
               shift_r <= 32'h0;
            end                                 // R11: earlier data dropped
         end else if (serial_mode == `WS_MODE_SERIAL) begin
            // Serial words build up in the window, first bit on top
            if (ser_valid) begin
               shift_r <= {shift_r[30:0], ser_bit}; // R19
               if (sbit_r == 5'h1F) begin
                  // Thirty-second bit closes a word
                  word_valid <= 1'b1;           // R17
                  word_data  <= {shift_r[30:0], ser_bit};
               end
            end
         end else if (asm_valid) begin
            // Parallel word from the packer, never a partial one
            word_valid <= 1'b1;                 // R17 R13 R14
            word_data  <= asm_data;
         end
      end
   end

   // Serial bit index within a word, restarted by sync
   // A wrap from 31 to 0 marks the next word boundary
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sbit_r <= 5'h0;
      end else if (ce) begin
         if (relock || !synced) begin
            // Alignment is only known once the sync word is seen
            sbit_r <= 5'h0;
         end else if (serial_mode == `WS_MODE_SERIAL && ser_valid) begin
            // One more bit of the current word
            sbit_r <= sbit_r + 5'h1;
         end
      end
   end

   // Start-up quiet window: covers the glitch cycle plus the quiet time
   // The pulse can reach user logic one clock after start-up completes,
   // so the hold opens at that edge and drops once the quiet time is over
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eos_d_r         <= 1'b0;
         pulse_seen_r    <= 1'b0;
         quiet_r         <= 3'h0;
         user_input_hold <= 1'b0;
      end else if (ce) begin
         eos_d_r <= startup_complete;
         if (startup_complete && !eos_d_r) begin
            // Rising edge of start-up done opens the window
            user_input_hold <= 1'b1;            // R15
            pulse_seen_r    <= 1'b0;
            quiet_r         <= 3'h0;
         end else if (user_input_hold) begin
            if (!pulse_seen_r) begin
               // The glitch cycle itself
               pulse_seen_r <= 1'b1;
            end else if (quiet_r == quiet_last[2:0]) begin
               // Quiet time over: inputs are safe from this edge on
               user_input_hold <= 1'b0;         // R16
            end else begin
               // Count quiet time after the glitch cycle
               quiet_r <= quiet_r + 3'h1;
            end
         end
      end
   end
endmodule // config_bus_width_sync_detect

//--- test/cfg_host_model.sv
`timescale 1ns/1ps
// Configuration host: drives parallel beats or serial bits, one per edge
module cfg_host_model (
   input  wire        clk,
   output reg         par_valid,
   output reg  [31:0] par_data,
   output reg         ser_valid,
   output reg         ser_bit
);
   // Quiet bus at time zero
   initial begin
      par_valid = 1'b0;
      par_data  = 32'h0;
      ser_valid = 1'b0;
      ser_bit   = 1'b0;
   end
   // One beat, held until the edge that takes it
   task put(input [31:0] d);
      begin
         par_valid <= 1'b1;
         par_data  <= d;
         @(posedge clk);
      end
   endtask
   // Released lines toggle every idle cycle, so every second cycle shows the last value again
   task idle(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            par_valid <= 1'b0;
            par_data  <= ~par_data;
            ser_valid <= 1'b0;
            ser_bit   <= ~ser_bit;
            @(posedge clk);
         end
      end
   endtask
   // Serial word, most significant bit first
   task bits(input [31:0] d);
      integer i;
      begin
         for (i = 31; i >= 0; i = i - 1) begin
            ser_valid <= 1'b1;
            ser_bit   <= d[i];
            @(posedge clk);
         end
      end
   endtask
endmodule // cfg_host_model

//--- test/config_bus_width_sync_detect_checker.sv
`timescale 1ns/1ps
`include "width_sync_map.vh"
module cbw_sync_checker (
   input wire        clk,
   input wire        rst_n,
   input wire        ce,
   input wire        serial_mode,
   input wire        program_pulse,
   input wire        scan_program_reset,
   input wire        internal_reprogram_reset,
   input wire        par_valid,
   input wire [31:0] par_data,
   input wire        ser_valid,
   input wire        ser_bit,
   input wire        startup_complete,
   input wire [1:0]  bus_width,
   input wire        width_locked,
   input wire        synced,
   input wire        word_valid,
   input wire [31:0] word_data,
   input wire        user_input_hold
);
   wire tk = ce && par_valid && !serial_mode && !width_locked; // Beat taken while hunting
   wire rs = ce && (program_pulse || scan_program_reset || internal_reprogram_reset);
   reg  lead_r;                                                // Last low byte was lead
   // Remembers whether the previous hunted beat carried the lead byte
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         lead_r <= 1'b0;
      else if (rs)
         lead_r <= 1'b0;
      else if (ce && serial_mode)
         lead_r <= 1'b0;
      else if (tk)
         lead_r <= (par_data[7:0] == `WS_PAT_LEAD);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Code byte after lead locks the matching width
   property p_code(c, w);
      tk && !rs && lead_r && par_data[7:0] == c |=> width_locked && bus_width == w;
   endproperty
   a_x8_lock: assert property (p_code(`WS_PAT_X8, `WS_WIDTH_X8)) else $error("x8 lock");
   a_x16_lock: assert property (p_code(`WS_PAT_X16, `WS_WIDTH_X16)) else $error("x16 lock");
   a_x32_lock: assert property (p_code(`WS_PAT_X32, `WS_WIDTH_X32)) else $error("x32 lock");
   a_bad_code: assert property (tk && lead_r && !(par_data[7:0] inside {`WS_PAT_X8,
      `WS_PAT_X16, `WS_PAT_X32}) |=> !width_locked) else $error("bad code locked");
   a_serial_skip: assert property (serial_mode && !width_locked |=> !width_locked)
      else $error("serial locked width");
   a_width_hold: assert property (width_locked && !rs |=> width_locked && $stable(bus_width))
      else $error("width changed");
   a_source_clear: assert property (rs |=> !width_locked && !synced)
      else $error("reset source ignored");
   a_sync_x32: assert property (ce && par_valid && !rs && !serial_mode && width_locked
      && bus_width == `WS_WIDTH_X32 && par_data == `WS_SYNC_WORD |=> synced)
      else $error("sync missed");
   a_sync_order: assert property (synced && !serial_mode |-> width_locked)
      else $error("sync before width");
   a_no_early_word: assert property (word_valid |-> synced) else $error("early word");
   a_hold_window: assert property ($rose(user_input_hold) |-> ##[1:8] !user_input_hold)
      else $error("hold stuck");
   a_hold_len: assert property ($rose(user_input_hold) |->
      user_input_hold [*5] ##1 !user_input_hold) else $error("hold length");
   a_ce_freeze: assert property (!ce |=> $stable(width_locked) && $stable(bus_width)
      && $stable(synced) && $stable(word_valid) && $stable(user_input_hold))
      else $error("state moved while frozen");
   c_x16: cover property (width_locked && bus_width == `WS_WIDTH_X16);
   c_synced: cover property ($rose(synced));
   c_word: cover property (word_valid);
   c_hold: cover property (user_input_hold);
endmodule // cbw_sync_checker
bind config_bus_width_sync_detect cbw_sync_checker u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
   .serial_mode(serial_mode), .program_pulse(program_pulse),
   .scan_program_reset(scan_program_reset), .internal_reprogram_reset(internal_reprogram_reset),
   .par_valid(par_valid), .par_data(par_data), .ser_valid(ser_valid), .ser_bit(ser_bit),
   .startup_complete(startup_complete), .bus_width(bus_width), .width_locked(width_locked),
   .synced(synced), .word_valid(word_valid), .word_data(word_data),
   .user_input_hold(user_input_hold));

//--- test/test_config_bus_width_sync_detect.sv
`timescale 1ns/1ps
`include "width_sync_map.vh"
module test_config_bus_width_sync_detect;
   reg         clk;                      // Bench clock
   reg         rst_n;                    // Power-on reset
   reg         ce;                       // Clock enable
   reg         serial_mode;              // Loading mode
   reg         startup_complete;         // Start-up done
   reg         program_pulse;            // Reprogram sources
   reg         scan_program_reset;
   reg         internal_reprogram_reset;
   wire        par_valid;                // Host-driven inputs
   wire [31:0] par_data;
   wire        ser_valid;
   wire        ser_bit;
   wire [1:0]  bus_width;                // Block outputs
   wire        width_locked;
   wire        synced;
   wire        word_valid;
   wire [31:0] word_data;
   wire        user_input_hold;
   reg  [31:0] last_word;                // Last emitted word
   integer     n_errors;
   integer     cmp_count;
   config_bus_width_sync_detect u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .serial_mode(serial_mode), .program_pulse(program_pulse),
      .scan_program_reset(scan_program_reset), .internal_reprogram_reset(internal_reprogram_reset),
      .par_valid(par_valid), .par_data(par_data), .ser_valid(ser_valid), .ser_bit(ser_bit),
      .startup_complete(startup_complete), .bus_width(bus_width), .width_locked(width_locked),
      .synced(synced), .word_valid(word_valid), .word_data(word_data),
      .user_input_hold(user_input_hold));
   cfg_host_model u_host (.clk(clk), .par_valid(par_valid), .par_data(par_data),
      .ser_valid(ser_valid), .ser_bit(ser_bit));
   always #25 clk = ~clk; // 20 MHz
   // Captures each word pulse
   always @(posedge clk) if (word_valid === 1'b1) last_word <= word_data;
   task check(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // Pulses one of the three lock-clearing sources
   task src(input integer k);
      begin
         program_pulse <= (k == 0);
         scan_program_reset <= (k == 1);
         internal_reprogram_reset <= (k == 2);
         u_host.idle(1);
         {program_pulse, scan_program_reset, internal_reprogram_reset} <= 3'h0;
         u_host.idle(2);
         check("locked", width_locked, 32'h0);
         check("synced", synced, 32'h0);
      end
   endtask
   // Lock flag and width code after a code beat
   task lock_is(input [1:0] w);
      begin
         u_host.idle(2);
         check("locked", width_locked, 32'h1);
         check("width", {30'h0, bus_width}, {30'h0, w});
      end
   endtask
   task t_x8;
      begin
         src(0);
         u_host.put(32'hFFFFFFFF);
         u_host.put(32'hFFFFFFBB);
         u_host.put(32'h5A5A5A11);
         lock_is(`WS_WIDTH_X8);
         u_host.put(32'h66);
         u_host.put(32'hAA);
         u_host.put(32'h99);
         u_host.put(32'h55);
         u_host.put(32'h66);
         u_host.put(32'h12);
         u_host.put(32'h34);
         u_host.put(32'h56);
         u_host.put(32'h78);
         u_host.idle(4);
         check("x8 word", last_word, 32'h12345678);
      end
   endtask
   task t_x16;
      begin
         src(1);
         u_host.put(32'h000000BB);
         u_host.put(32'h00001122);
         lock_is(`WS_WIDTH_X16);
         u_host.put(32'h0000AA99);
         u_host.put(32'h00005566);
         u_host.put(32'h0000ABCD);
         u_host.put(32'h00001234);
         u_host.idle(4);
         check("x16 word", last_word, 32'hABCD1234);
      end
   endtask
   task t_x32;
      begin
         src(2);
         u_host.put(32'h000000BB);
         u_host.put(32'h11002233);
         u_host.idle(2);
         check("bad code", width_locked, 32'h0);
         u_host.put(32'h000000BB);
         u_host.put(32'h000000BB);
         u_host.put(32'h11002244);
         lock_is(`WS_WIDTH_X32);
         u_host.put(32'h000000BB);
         u_host.put(32'h00000011);
         lock_is(`WS_WIDTH_X32);
         check("presync", synced, 32'h0);
         u_host.put(`WS_SYNC_WORD);
         u_host.put(32'h30008001);
         u_host.idle(4);
         check("x32 word", last_word, 32'h30008001);
      end
   endtask
   // Clock enable freezes a code beat; a power cycle drops the lock
   task t_freeze;
      begin
         src(2);
         u_host.put(32'h000000BB);
         ce <= 1'b0;
         u_host.put(32'h00000011);
         check("frozen", width_locked, 32'h0);
         ce <= 1'b1;
         u_host.put(32'h00000011);
         lock_is(`WS_WIDTH_X8);
         rst_n <= 1'b0;
         u_host.idle(2);
         check("rst width", {30'h0, bus_width}, 32'h0);
         rst_n <= 1'b1;
         u_host.idle(2);
         check("rst locked", width_locked, 32'h0);
      end
   endtask
   task t_serial;
      begin
         src(0);
         serial_mode <= 1'b1;
         u_host.bits(32'h000000BB);
         u_host.bits(32'h11220044);
         u_host.idle(2);
         check("ser width", width_locked, 32'h0);
         u_host.bits(32'h0000005A);
         u_host.bits(`WS_SYNC_WORD);
         u_host.idle(2);
         check("ser sync", synced, 32'h1);
         u_host.bits(32'h20000000);
         u_host.idle(4);
         check("ser word", last_word, 32'h20000000);
      end
   endtask
   task t_startup;
      integer i, n;
      begin
         n = 0;
         startup_complete <= 1'b1;
         for (i = 0; i < 12; i = i + 1) begin
            @(negedge clk);
            if (user_input_hold === 1'b1)
               n = n + 1;
         end
         check("hold cycles", n, 1 + `WS_QUIET_CYC);
         check("hold end", user_input_hold, 32'h0);
      end
   endtask
   // Main sequence
   initial begin
      {clk, rst_n, serial_mode, startup_complete} = 4'h0;
      {program_pulse, scan_program_reset, internal_reprogram_reset} = 3'h0;
      ce = 1'b1;
      last_word = 32'h0;
      n_errors = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_x8;
      t_x16;
      t_x32;
      t_freeze;
      t_serial;
      t_startup;
      print_verdict;
   end
   // Tests need a few hundred cycles; 20000 cycles means a hang
   initial begin
      #1000000;
      n_errors = n_errors + 1;
      print_verdict;
   end
endmodule // test_config_bus_width_sync_detect
